// ---- logic/fit_pins.sv ----
// Local design decisions: the register addresses and register access over APB.
module fit_pins (
  input wire logic core_clk,
  input wire logic sys_rst,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic [fit_pkg::FLAG_COUNT-1:0] programFlagPinsIn,
  output logic [fit_pkg::FLAG_COUNT-1:0] programFlagPinsOut,
  output logic [fit_pkg::FLAG_COUNT-1:0] programFlagPinsOe,
  output logic [fit_pkg::FLAG_COUNT-1:0] flagCond,
  input wire logic [fit_pkg::IRQ_COUNT-1:0] externalInterruptRequestPins,
  input wire logic [fit_pkg::IRQ_COUNT-1:0] coreIrqAck,
  output logic [fit_pkg::IRQ_COUNT-1:0] coreIrqReq,
  input wire logic irqBootStrapPin,
  input wire logic vectorsReady,
  input wire logic timerZeroExpire,
  input wire logic timerZeroExpiredIn,
  output logic timerZeroExpiredOut,
  output logic timerZeroExpiredOe,
  output logic timerStrapLevel,
  output logic irqOut
);
  import fit_pkg::*;

  logic [SYNC_WIDTH-1:0] syncIn;
  logic [SYNC_WIDTH-1:0] syncOut;
  logic [FLAG_COUNT-1:0] flagLvl;
  logic [IRQ_COUNT-1:0] irqLvl;
  logic timerPinLvl;
  logic bootPinLvl;
  logic [FLAG_COUNT-1:0] flagDir;
  logic [FLAG_COUNT-1:0] flagValue;
  logic [IRQ_COUNT-1:0] irqMode;
  logic [IRQ_COUNT-1:0] irqEnable;
  logic [IRQ_COUNT-1:0] irqPrev;
  logic [IRQ_COUNT-1:0] irqPending;
  logic [IRQ_COUNT-1:0] irqRise;
  logic [IRQ_COUNT-1:0] irqEvent;
  logic [STAT_WIDTH-1:0] intStatus;
  logic [STAT_WIDTH-1:0] intMask;
  logic [STAT_WIDTH-1:0] statReported;
  logic irqBootStrap;
  fit_boot_t bootState;
  logic wrEn;
  logic rdEn;
  logic [31:0] next_prdata;
  logic next_pslverr;
  logic [STAT_WIDTH-1:0] next_reported;

  function automatic logic isMapped(input logic [7:0] addr);
    case (addr)
      OFS_FLAG_DIR, OFS_FLAG_OUT, OFS_FLAG_IN, OFS_IRQ_MODE,
      OFS_IRQ_EN, OFS_INT_STAT, OFS_INT_MASK, OFS_STRAP: begin
        return 1'b1;
      end
      default: begin
        return 1'b0;
      end
    endcase
  endfunction : isMapped

  function automatic logic regWrite(input logic en, input logic [7:0] addr,
                                    input logic [7:0] ofs);
    return en && (addr == ofs);
  endfunction : regWrite

  assign syncIn = {irqBootStrapPin, timerZeroExpiredIn,
                   externalInterruptRequestPins, programFlagPinsIn};

  fit_sync #(
    .WIDTH(SYNC_WIDTH)
  ) u_sync (
    .core_clk(core_clk),
    .asyncIn(syncIn),
    .syncOut(syncOut)
  );

  assign flagLvl = syncOut[FLAG_COUNT-1:0];
  assign irqLvl = syncOut[FLAG_COUNT+IRQ_COUNT-1:FLAG_COUNT];
  assign timerPinLvl = syncOut[SYNC_WIDTH-2];
  assign bootPinLvl = syncOut[SYNC_WIDTH-1];

  // APB: one wait state, access completes when pready is high
  assign wrEn = psel && penable && pready && pwrite;
  assign rdEn = psel && penable && pready && !pwrite;

  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      pready <= 1'b0;
    end else begin
      pready <= psel && penable && !pready;
    end
  end

  always_comb begin
    next_prdata = 32'h0000_0000;
    next_pslverr = !isMapped(paddr);
    next_reported = '0;
    case (paddr)
      OFS_FLAG_DIR: begin
        next_prdata[FLAG_COUNT-1:0] = flagDir;
      end
      OFS_FLAG_OUT: begin
        next_prdata[FLAG_COUNT-1:0] = flagValue;
      end
      OFS_FLAG_IN: begin
        next_prdata[FLAG_COUNT-1:0] = flagCond;
      end
      OFS_IRQ_MODE: begin
        next_prdata[IRQ_COUNT-1:0] = irqMode;
      end
      OFS_IRQ_EN: begin
        next_prdata[IRQ_COUNT-1:0] = irqEnable;
      end
      OFS_INT_STAT: begin
        next_prdata[STAT_WIDTH-1:0] = intStatus;
        next_reported = intStatus;
      end
      OFS_INT_MASK: begin
        next_prdata[STAT_WIDTH-1:0] = intMask;
      end
      OFS_STRAP: begin
        next_prdata[1:0] = {irqBootStrap, timerStrapLevel};
      end
      default: begin
        next_prdata = 32'h0000_0000;
      end
    endcase
  end

  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      prdata <= 32'h0000_0000;
      pslverr <= 1'b0;
      statReported <= '0;
    end else if (psel && penable && !pready) begin
      prdata <= pwrite ? 32'h0000_0000 : next_prdata;
      pslverr <= next_pslverr;
      statReported <= pwrite ? '0 : next_reported;
    end else if (!psel) begin
      prdata <= 32'h0000_0000;
      pslverr <= 1'b0;
      statReported <= '0;
    end
  end

  // Flag direction and drive
  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      flagDir <= RST_FLAG_DIR;
      flagValue <= RST_FLAG_OUT;
    end else begin
      if (regWrite(wrEn, paddr, OFS_FLAG_DIR)) begin
        flagDir <= pwdata[FLAG_COUNT-1:0];
      end
      if (regWrite(wrEn, paddr, OFS_FLAG_OUT)) begin
        flagValue <= pwdata[FLAG_COUNT-1:0];
      end
    end
  end

  assign programFlagPinsOut = flagValue;
  assign programFlagPinsOe = flagDir;

  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      flagCond <= '0;
    end else begin
      flagCond <= flagLvl;
    end
  end

  // Strap capture while reset is held
  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      timerStrapLevel <= timerPinLvl;
      irqBootStrap <= bootPinLvl;
    end
  end

  // Boot-time enable of request inputs
  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      bootState <= FIT_BOOT_WAIT;
    end else begin
      case (bootState)
        FIT_BOOT_WAIT: begin
          bootState <= irqBootStrap ? FIT_BOOT_ARMED : FIT_BOOT_DONE;
        end
        FIT_BOOT_ARMED: begin
          if (vectorsReady) begin
            bootState <= FIT_BOOT_DONE;
          end
        end
        FIT_BOOT_DONE: begin
          bootState <= FIT_BOOT_DONE;
        end
        default: begin
          bootState <= FIT_BOOT_DONE;
        end
      endcase
    end
  end

  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      irqEnable <= RST_IRQ_EN;
      irqMode <= RST_IRQ_MODE;
    end else begin
      if (bootState == FIT_BOOT_ARMED && vectorsReady) begin
        irqEnable <= BOOT_IRQ_EN;
      end
      if (regWrite(wrEn, paddr, OFS_IRQ_EN)) begin
        irqEnable <= pwdata[IRQ_COUNT-1:0];
      end
      if (regWrite(wrEn, paddr, OFS_IRQ_MODE)) begin
        irqMode <= pwdata[IRQ_COUNT-1:0];
      end
    end
  end

  // Request detection: mode bit high selects edge
  assign irqRise = irqLvl & ~irqPrev;
  assign irqEvent = irqEnable & ((irqMode & irqRise)
                    | (~irqMode & irqLvl));

  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      irqPrev <= '0;
    end else begin
      irqPrev <= irqLvl;
    end
  end

  // Edge pending held until acknowledged; a new edge beats the ack
  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      irqPending <= '0;
    end else begin
      irqPending <= ((irqPending & ~coreIrqAck) | irqRise)
                    & irqMode & irqEnable;
    end
  end

  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      coreIrqReq <= '0;
    end else begin
      coreIrqReq <= irqEnable & ((irqMode & (irqRise |
                    (irqPending & ~coreIrqAck))) |
                    (~irqMode & irqLvl));
    end
  end

  // Timer pin: released only after reset, pulse one cycle per expiry
  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      timerZeroExpiredOut <= 1'b0;
      timerZeroExpiredOe <= 1'b0;
    end else begin
      timerZeroExpiredOut <= timerZeroExpire;
      timerZeroExpiredOe <= 1'b1;
    end
  end

  // Sticky status; reported bits cleared by the read, set wins
  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      intStatus <= '0;
      intMask <= RST_INT_MASK;
    end else begin
      intStatus <= (intStatus & ~(rdEn && paddr == OFS_INT_STAT ?
                    statReported : '0)) | {timerZeroExpire, irqEvent};
      if (regWrite(wrEn, paddr, OFS_INT_MASK)) begin
        intMask <= pwdata[STAT_WIDTH-1:0];
      end
    end
  end

  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      irqOut <= 1'b0;
    end else begin
      irqOut <= |(intStatus & intMask);
    end
  end

  chk_flag_reset: assert property (
    @(posedge core_clk) sys_rst |=> programFlagPinsOe == '0)
    else $error("flag pins not inputs after reset");

  chk_flag_dir_write: assert property (
    @(posedge core_clk) disable iff (sys_rst)
    regWrite(wrEn, paddr, OFS_FLAG_DIR)
    |=> programFlagPinsOe == $past(pwdata[FLAG_COUNT-1:0]))
    else $error("flag direction not taken from write");

  chk_flag_cond_lag: assert property (
    @(posedge core_clk) disable iff (sys_rst)
    !$past(sys_rst, 3) |-> flagCond == $past(programFlagPinsIn, 3))
    else $error("flag condition not three cycles behind pin");

  chk_sync_depth: assert property (
    @(posedge core_clk) disable iff (sys_rst)
    !$past(irqMode[1]) && $past(irqEnable[1])
    && !$past(sys_rst, 4)
    |-> coreIrqReq[1] == $past(externalInterruptRequestPins[1], 3))
    else $error("level request not through two sync stages");

  chk_irq_disabled: assert property (
    @(posedge core_clk) disable iff (sys_rst)
    $past(irqEnable) == '0 |-> coreIrqReq == '0)
    else $error("core request while inputs disabled");

  chk_boot_off: assert property (
    @(posedge core_clk)
    $fell(sys_rst) && !irqBootStrap |-> (irqEnable == '0) [*2])
    else $error("requests enabled without boot strap");

  chk_edge_hold: assert property (
    @(posedge core_clk) disable iff (sys_rst)
    coreIrqReq[0] && irqMode[0] && irqEnable[0] && !coreIrqAck[0]
    && $past(irqMode[0]) && $past(irqEnable[0]) |=> coreIrqReq[0])
    else $error("edge request dropped before ack");

  chk_timer_pulse: assert property (
    @(posedge core_clk) disable iff (sys_rst)
    timerZeroExpire |=> timerZeroExpiredOut)
    else $error("no pulse after timer expiry");

  chk_timer_width: assert property (
    @(posedge core_clk) disable iff (sys_rst)
    timerZeroExpire ##1 !timerZeroExpire |=> !timerZeroExpiredOut)
    else $error("timer pulse longer than one cycle");

  chk_strap_float: assert property (
    @(posedge core_clk) sys_rst |=> !timerZeroExpiredOe)
    else $error("timer pin driven during reset");

  cov_edge_request: cover property (
    @(posedge core_clk) disable iff (sys_rst)
    irqMode[0] && irqEnable[0] && coreIrqReq[0] ##1 coreIrqAck[0]);

  cov_flag_output: cover property (
    @(posedge core_clk) disable iff (sys_rst)
    $rose(programFlagPinsOe[0]));

  cov_status_read: cover property (
    @(posedge core_clk) disable iff (sys_rst)
    rdEn && paddr == OFS_INT_STAT && irqOut);

  cov_boot_enable: cover property (
    @(posedge core_clk) disable iff (sys_rst)
    bootState == FIT_BOOT_ARMED ##1 irqEnable == BOOT_IRQ_EN);
endmodule : fit_pins

// ---- logic/fit_pkg.sv ----
package fit_pkg;
  localparam int FLAG_COUNT = 4;
  localparam int IRQ_COUNT = 4;
  localparam int STAT_WIDTH = IRQ_COUNT + 1;
  localparam int STAT_TIMER_BIT = 4;
  localparam int SYNC_WIDTH = FLAG_COUNT + IRQ_COUNT + 2;

  localparam logic [7:0] OFS_FLAG_DIR = 8'h00;
  localparam logic [7:0] OFS_FLAG_OUT = 8'h04;
  localparam logic [7:0] OFS_FLAG_IN = 8'h08;
  localparam logic [7:0] OFS_IRQ_MODE = 8'h0c;
  localparam logic [7:0] OFS_IRQ_EN = 8'h10;
  localparam logic [7:0] OFS_INT_STAT = 8'h14;
  localparam logic [7:0] OFS_INT_MASK = 8'h18;
  localparam logic [7:0] OFS_STRAP = 8'h1c;

  localparam logic [FLAG_COUNT-1:0] RST_FLAG_DIR = 4'h0;
  localparam logic [FLAG_COUNT-1:0] RST_FLAG_OUT = 4'h0;
  localparam logic [IRQ_COUNT-1:0] RST_IRQ_MODE = 4'h0;
  localparam logic [IRQ_COUNT-1:0] RST_IRQ_EN = 4'h0;
  localparam logic [IRQ_COUNT-1:0] BOOT_IRQ_EN = 4'hf;
  localparam logic [STAT_WIDTH-1:0] RST_INT_MASK = 5'h00;

  typedef enum logic [1:0] {
    FIT_BOOT_WAIT,
    FIT_BOOT_ARMED,
    FIT_BOOT_DONE
  } fit_boot_t;
endpackage : fit_pkg

// ---- logic/fit_sync.sv ----
module fit_sync #(
  parameter int WIDTH = 1
) (
  input wire logic core_clk,
  input wire logic [WIDTH-1:0] asyncIn,
  output logic [WIDTH-1:0] syncOut
);
  logic [WIDTH-1:0] stageOne;

  // No reset, so straps are visible while reset is held
  always_ff @(posedge core_clk) begin
    stageOne <= asyncIn;
    syncOut <= stageOne;
  end
endmodule : fit_sync

// ---- verif/fit_ext_sys.sv ----
module fit_ext_sys (
  input wire logic sys_rst,
  input wire logic [3:0] drvEn,
  input wire logic [3:0] drvVal,
  input wire logic [3:0] devOe,
  input wire logic [3:0] devOut,
  output logic [3:0] flagPin,
  input wire logic strapLevel,
  input wire logic timer_zero_expired_out,
  input wire logic tmrOut,
  output logic tmrPin
);
  timeunit 1ns;
  timeprecision 1ps;
  // Pull-up holds an undriven flag pin high
  always_comb begin
    for (int i = 0; i < 4; i++) begin
      flagPin[i] = devOe[i] ? devOut[i] : (drvEn[i] ? drvVal[i] : 1'b1);
    end
  end
  // Strap level held only while reset is applied
  assign tmrPin = timer_zero_expired_out ? tmrOut : (sys_rst ? strapLevel : ~tmrOut);
endmodule : fit_ext_sys

// ---- verif/tb_top.sv ----
module tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  import fit_pkg::*;
  logic core_clk = 1'b0;
  logic sys_rst = 1'b1;
  logic psel = 1'b0, penable = 1'b0, pwrite = 1'b0, pready, pslverr, er;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0, prdata, rd;
  logic [3:0] flagPin, flagOut, flagOe, flagCond, irqReq;
  logic [3:0] drvEn = 4'h0, drvVal = 4'h0, irqPins = 4'h0, irqAck = 4'h0;
  logic bootStrap = 1'b0, vecReady = 1'b0, tmrExp = 1'b0, strap = 1'b0;
  logic tmrPin, tmrOut, timer_zero_expired_out, tmrStrap, irqOut;
  int errors = 0, cmp_count = 0, cycles = 0;

  fit_pins dut (
    .core_clk, .sys_rst, .psel, .penable, .pwrite, .paddr, .pwdata,
    .prdata, .pready, .pslverr,
    .programFlagPinsIn(flagPin), .programFlagPinsOut(flagOut),
    .programFlagPinsOe(flagOe), .flagCond(flagCond),
    .externalInterruptRequestPins(irqPins), .coreIrqAck(irqAck),
    .coreIrqReq(irqReq), .irqBootStrapPin(bootStrap),
    .vectorsReady(vecReady), .timerZeroExpire(tmrExp),
    .timerZeroExpiredIn(tmrPin), .timerZeroExpiredOut(tmrOut),
    .timerZeroExpiredOe(timer_zero_expired_out), .timerStrapLevel(tmrStrap), .irqOut(irqOut)
  );
  fit_ext_sys ext (
    .sys_rst, .drvEn, .drvVal, .devOe(flagOe), .devOut(flagOut), .flagPin,
    .strapLevel(strap), .timer_zero_expired_out, .tmrOut, .tmrPin
  );

  initial begin
    forever #20 core_clk = ~core_clk;
  end
  always @(posedge core_clk) begin
    cycles <= cycles + 1;
    if (cycles == 4000) begin
      errors++;
      $display("Error at %0t: cycles %h limit %h", $time, cycles, 4000);
      stop_test();
    end
  end

  task chk(input logic [31:0] got, input logic [31:0] exp);
    cmp_count++;
    if (got !== exp) begin
      errors++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk

  task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge core_clk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge core_clk);
    penable <= 1'b1;
    do begin
      @(posedge core_clk);
    end while (pready !== 1'b1);
    rd = prdata;
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb

  task rdchk(input logic [7:0] a, input logic [31:0] exp);
    apb(1'b0, a, 32'h0);
    chk(rd, exp);
  endtask : rdchk

  task t_reset(input logic s, input logic b);
    @(posedge core_clk);
    sys_rst <= 1'b1;
    strap <= s;
    bootStrap <= b;
    repeat (12) @(posedge core_clk);
    sys_rst <= 1'b0;
    @(negedge core_clk);
    chk(flagOe, 4'h0);
    chk(tmrStrap, s);
    rdchk(OFS_STRAP, {b, s});
    rdchk(OFS_FLAG_DIR, 32'h0);
    rdchk(OFS_IRQ_MODE, 32'h0);
    rdchk(OFS_INT_MASK, 32'h0);
    rdchk(OFS_IRQ_EN, 32'h0);
    vecReady <= 1'b1;
    repeat (3) @(posedge core_clk);
    rdchk(OFS_IRQ_EN, b ? 32'hf : 32'h0);
    vecReady <= 1'b0;
  endtask : t_reset

  task t_flags();
    apb(1'b1, OFS_FLAG_DIR, 32'h3);
    apb(1'b1, OFS_FLAG_OUT, 32'ha);
    drvEn <= 4'hc;
    drvVal <= 4'h4;
    @(negedge core_clk);
    chk(flagOe, 4'h3);
    chk(flagOut, 4'ha);
    repeat (5) @(negedge core_clk);
    chk(flagCond, 4'h6);
    rdchk(OFS_FLAG_IN, 32'h6);
    drvEn <= 4'h0;
    apb(1'b1, OFS_FLAG_DIR, 32'h0);
    repeat (5) @(negedge core_clk);
    chk(flagCond, 4'hf);
  endtask : t_flags

  task t_irq();
    apb(1'b1, OFS_IRQ_MODE, 32'h1);
    apb(1'b1, OFS_IRQ_EN, 32'hf);
    irqPins <= 4'h2;
    repeat (5) @(negedge core_clk);
    chk(irqReq, 4'h2);
    @(posedge core_clk) irqPins <= 4'h3;
    repeat (2) @(posedge core_clk);
    irqPins <= 4'h0;
    repeat (5) @(negedge core_clk);
    chk(irqReq, 4'h1);
    chk(irqOut, 1'b0);
    @(posedge core_clk) irqAck <= 4'h1;
    @(posedge core_clk) irqAck <= 4'h0;
    @(negedge core_clk) chk(irqReq, 4'h0);
    rdchk(OFS_INT_STAT, 32'h3);
    rdchk(OFS_INT_STAT, 32'h0);
    irqPins <= 4'h2;
    repeat (5) @(negedge core_clk);
    rdchk(OFS_INT_STAT, 32'h2);
    rdchk(OFS_INT_STAT, 32'h2);
    apb(1'b1, OFS_IRQ_EN, 32'h0);
    irqPins <= 4'h2;
    repeat (5) @(negedge core_clk);
    chk(irqReq, 4'h0);
    @(posedge core_clk) irqPins <= 4'h0;
    apb(1'b0, OFS_INT_STAT, 32'h0);
  endtask : t_irq

  task t_timer();
    apb(1'b1, OFS_INT_MASK, 32'h10);
    chk(timer_zero_expired_out, 1'b1);
    @(posedge core_clk) tmrExp <= 1'b1;
    @(negedge core_clk) chk(tmrPin, 1'b0);
    @(posedge core_clk) tmrExp <= 1'b0;
    @(negedge core_clk) chk(tmrPin, 1'b1);
    @(negedge core_clk) chk(tmrPin, 1'b0);
    @(negedge core_clk) chk(irqOut, 1'b1);
    rdchk(OFS_INT_STAT, 32'h10);
    repeat (2) @(negedge core_clk);
    chk(irqOut, 1'b0);
  endtask : t_timer

  task t_unmapped();
    apb(1'b1, 8'h40, 32'hffffffff);
    chk(er, 1'b1);
    rdchk(8'h40, 32'h0);
    chk(er, 1'b1);
  endtask : t_unmapped

  task stop_test();
    $display("Compares %0d, mismatches %0d", cmp_count, errors);
    if (errors == 0 && cmp_count > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask : stop_test

  initial begin
    t_reset(1'b1, 1'b0);
    t_reset(1'b0, 1'b1);
    t_flags();
    t_irq();
    t_timer();
    t_unmapped();
    stop_test();
  end
endmodule : tb_top
